/* hdl/mic_irq_ctrl.sv */
// interrupt controller: flag capture, enable gating, sleep wake, service sequencing, avalon slave
// assumes peripheral events and core strobes are one-clock pulses on clk; pins are asynchronous
`timescale 1ns/1ns
module mic_irq_ctrl #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ext_irq_pin,
    input  wire logic [5:0]  port_pins,
    input  wire logic        port_op_active,
    input  wire logic [7:0]  tick_counter,
    input  wire logic        comparator_event,
    input  wire logic        conversion_done_event,
    input  wire logic        wide_timer_overflow_event,
    input  wire logic        period_match_event,
    input  wire logic        capcomp_event,
    input  wire logic        return_from_handler_instr,
    input  wire logic        sleep_instr,
    output logic             q1_phase,
    output logic             service_req,
    output logic             vector_load,
    output logic             push_return,
    output logic      [12:0] vector_addr,
    output logic             wake_pulse,
    output logic             asleep,
    output logic      [5:0]  port_read_value
);

    // instruction-cycle phase divider
    logic [1:0] q_phase;
    // pin synchronisers
    logic                      ext_meta;
    logic                      ext_sync;
    logic                      ext_last;
    logic [mic_pkg::PORT_W-1:0] port_meta;
    logic [mic_pkg::PORT_W-1:0] port_sync;
    logic [mic_pkg::PORT_W-1:0] port_last;
    logic [7:0]                tick_prev;
    logic                      ext_pending;
    // registers
    logic [7:0]                interrupt_control;
    logic [mic_pkg::PORT_W-1:0] change_pin_select;
    logic [7:0]                peripheral_flags;
    logic [7:0]                peripheral_enables;
    logic                      ext_edge_select;
    logic [mic_pkg::PORT_W-1:0] analog_pin_select;
    logic                      ext_en_at_sleep;
    logic                      in_handler;
    // service sequencing
    mic_pkg::mic_svc_e         svc_state;
    logic [1:0]                svc_cnt;
    logic                      bus_ack;

    function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
        hit = (addr[4:2] == off[4:2]);
    endfunction

    // bus decode: one wait cycle, then the answer; writes are enabled by lane 0 alone
    wire       bus_req   = avs_read | avs_write;
    wire       wr_en     = avs_write & bus_ack & avs_byteenable[0];
    wire [7:0] wdata     = avs_writedata[7:0];
    wire       wr_ctrl   = wr_en & hit(avs_address, mic_pkg::OFF_CONTROL);
    wire       wr_chsel  = wr_en & hit(avs_address, mic_pkg::OFF_CHANGE_SEL);
    wire       wr_pflag  = wr_en & hit(avs_address, mic_pkg::OFF_PFLAGS);
    wire       wr_pen    = wr_en & hit(avs_address, mic_pkg::OFF_PENABLES);
    wire       wr_config = wr_en & hit(avs_address, mic_pkg::OFF_CONFIG);
    assign avs_waitrequest = bus_req & ~bus_ack;

    // phase decode
    wire q1_now     = (q_phase == mic_pkg::Q1_PHASE);
    wire ext_window = q1_now | (q_phase == mic_pkg::Q4_PHASE);
    assign q1_phase = q1_now;

    // analog pins read as zero, so they cannot produce edges or changes
    wire [mic_pkg::PORT_W-1:0] port_digital = port_sync & ~analog_pin_select; // R14
    wire ext_level = ext_sync & ~analog_pin_select[mic_pkg::EXT_PIN_IDX]; // R14

    // pin edge select and flag window; edges outside Q4/Q1 wait for the window
    wire edge_rise = ext_level & ~ext_last;
    wire edge_fall = ~ext_level & ext_last;
    wire edge_hit  = ext_edge_select ? edge_rise : edge_fall; // R11
    wire ext_set   = (edge_hit | ext_pending) & ext_window; // R12 R18

    // tick wrap and port change events
    wire tick_wrap = (tick_prev == mic_pkg::TICK_TOP) & (tick_counter == mic_pkg::TICK_ZERO); // R15
    // the change is dropped while the core touches the port, a documented limitation
    wire port_change = |((port_digital ^ port_last) & change_pin_select) & ~port_op_active; // R16 R17

    // peripheral events; absent sources are held at zero on the small variant
    wire [7:0] periph_mask = LARGE_VARIANT ? mic_pkg::PERIPH_MASK_LARGE
                                           : mic_pkg::PERIPH_MASK_SMALL; // R01
    wire [7:0] periph_raw;
    assign periph_raw[mic_pkg::CONV_BIT]       = conversion_done_event;
    assign periph_raw[mic_pkg::CAPCOMP_BIT]    = capcomp_event;
    assign periph_raw[mic_pkg::COMPARATOR_BIT] = comparator_event;
    assign periph_raw[mic_pkg::PERIOD_BIT]     = period_match_event;
    assign periph_raw[mic_pkg::WIDE_TIMER_BIT] = wide_timer_overflow_event;
    assign periph_raw[7]                       = 1'b0;
    assign periph_raw[4]                       = 1'b0;
    assign periph_raw[2]                       = 1'b0;
    wire [7:0] periph_events = periph_raw & periph_mask;

    // enable gating
    wire global_irq_enable       = interrupt_control[mic_pkg::GLOBAL_EN_BIT];
    wire tick_pend = interrupt_control[mic_pkg::TICK_EN_BIT]
                   & interrupt_control[mic_pkg::TICK_FLAG_BIT]; // R15
    wire ext_pend  = interrupt_control[mic_pkg::EXT_EN_BIT]
                   & interrupt_control[mic_pkg::EXT_FLAG_BIT]; // R12
    wire port_pend = interrupt_control[mic_pkg::PORT_EN_BIT]
                   & interrupt_control[mic_pkg::PORT_FLAG_BIT]; // R16
    wire periph_pend = interrupt_control[mic_pkg::PERIPH_EN_BIT]
                     & |(peripheral_flags & peripheral_enables); // R20
    wire any_pend  = tick_pend | ext_pend | port_pend | periph_pend;
    assign service_req = global_irq_enable & any_pend; // R02 R22

    // wake terms: pin counts only if enabled at sleep entry; global enable ignored
    wire ext_wake  = ext_en_at_sleep & interrupt_control[mic_pkg::EXT_FLAG_BIT]; // R13
    wire wake_pend = tick_pend | ext_wake | port_pend | periph_pend; // R21
    wire wake_now  = asleep & wake_pend;

    // service sequencing: armed at a q1, vectored three instruction cycles later
    wire take_ok  = global_irq_enable & any_pend & ~asleep; // R02 R07
    wire arm_now  = (svc_state == mic_pkg::MIC_IDLE) & q1_now & take_ok;
    wire take_now = (svc_state == mic_pkg::MIC_ARMED) & q1_now
                  & (svc_cnt == mic_pkg::SVC_LAST) & take_ok; // R08

    // next register values; a hardware set always wins over a software clear
    wire [7:0] ctrl_base = wr_ctrl ? wdata : interrupt_control;
    wire [7:0] ctrl_flagged;
    assign ctrl_flagged[7:3] = ctrl_base[7:3];
    assign ctrl_flagged[mic_pkg::TICK_FLAG_BIT] = ctrl_base[mic_pkg::TICK_FLAG_BIT] | tick_wrap; // R06
    assign ctrl_flagged[mic_pkg::EXT_FLAG_BIT]  = ctrl_base[mic_pkg::EXT_FLAG_BIT] | ext_set; // R06
    assign ctrl_flagged[mic_pkg::PORT_FLAG_BIT] = ctrl_base[mic_pkg::PORT_FLAG_BIT] | port_change;
    // vectoring clears the global enable, the return instruction sets it
    wire next_gie = take_now ? 1'b0 : (return_from_handler_instr ? 1'b1 : ctrl_base[7]); // R04 R05
    wire [7:0] next_control = {next_gie, ctrl_flagged[6:0]}; // R10
    wire [7:0] next_pflags  = ((wr_pflag ? wdata : peripheral_flags) | periph_events)
                            & periph_mask; // R06 R10
    wire [7:0] next_penables = (wr_pen ? wdata : peripheral_enables) & periph_mask;

    // sleep entry completes as a no-op when a wake term already stands
    wire next_asleep = wake_now ? 1'b0 : (sleep_instr & ~wake_pend) | asleep; // R21

    // read mux; unmapped addresses read zero
    wire [31:0] rd_control  = {24'h0, interrupt_control};
    wire [31:0] rd_chsel    = {26'h0, change_pin_select};
    wire [31:0] rd_pflags   = {24'h0, peripheral_flags};
    wire [31:0] rd_penables = {24'h0, peripheral_enables};
    wire [31:0] rd_config   = {18'h0, analog_pin_select, 7'h0, ext_edge_select};
    wire [31:0] rd_status   = {29'h0, asleep, in_handler, service_req};
    wire [31:0] rd_mux =
        hit(avs_address, mic_pkg::OFF_CONTROL)    ? rd_control  :
        hit(avs_address, mic_pkg::OFF_CHANGE_SEL) ? rd_chsel    :
        hit(avs_address, mic_pkg::OFF_PFLAGS)     ? rd_pflags   :
        hit(avs_address, mic_pkg::OFF_PENABLES)   ? rd_penables :
        hit(avs_address, mic_pkg::OFF_CONFIG)     ? rd_config   :
        hit(avs_address, mic_pkg::OFF_STATUS)     ? rd_status   : 32'h0;

    // phase divider, four clocks per instruction cycle
    always_ff @(posedge clk) begin
        if (!rst_b) q_phase <= mic_pkg::Q1_PHASE;
        else        q_phase <= 2'(q_phase + 2'h1);
    end

    // two-stage synchronisers; the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ext_meta  <= 1'b0;
            ext_sync  <= 1'b0;
            port_meta <= '0;
            port_sync <= '0;
        end else begin
            ext_meta  <= ext_irq_pin;
            ext_sync  <= ext_meta;
            port_meta <= port_pins;
            port_sync <= port_meta;
        end
    end

    // event history for edge, change and wrap detection
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ext_last        <= 1'b0;
            port_last       <= '0;
            tick_prev       <= mic_pkg::TICK_ZERO;
            ext_pending     <= 1'b0;
            port_read_value <= '0;
        end else begin
            ext_last        <= ext_level;
            port_last       <= port_digital;
            tick_prev       <= tick_counter;
            ext_pending     <= (edge_hit | ext_pending) & ~ext_window; // R18
            port_read_value <= port_digital; // R14
        end
    end

    // register file
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            interrupt_control  <= mic_pkg::CONTROL_RESET; // R03
            peripheral_flags   <= mic_pkg::PFLAGS_RESET;
            peripheral_enables <= mic_pkg::PENABLES_RESET;
            change_pin_select  <= mic_pkg::CHANGE_RESET;
            ext_edge_select    <= mic_pkg::EDGE_RESET;
            analog_pin_select  <= mic_pkg::ANALOG_RESET;
        end else begin
            interrupt_control  <= next_control;
            peripheral_flags   <= next_pflags;
            peripheral_enables <= next_penables;
            if (wr_chsel) change_pin_select <= wdata[mic_pkg::PORT_W-1:0];
            if (wr_config) begin
                ext_edge_select   <= wdata[mic_pkg::EDGE_SEL_BIT];
                analog_pin_select <= avs_writedata[mic_pkg::ANALOG_LSB +: mic_pkg::PORT_W];
            end
        end
    end

    // sleep state, pin enable captured at sleep entry
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            asleep          <= 1'b0;
            wake_pulse      <= 1'b0;
            ext_en_at_sleep <= 1'b0;
        end else begin
            asleep     <= next_asleep;
            wake_pulse <= wake_now; // R21
            if (sleep_instr & ~asleep)
                ext_en_at_sleep <= interrupt_control[mic_pkg::EXT_EN_BIT]; // R13
        end
    end

    // service state machine; losing the request or global enable while armed aborts,
    // and the request simply stays pending in its flag
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            svc_state <= mic_pkg::MIC_IDLE;
            svc_cnt   <= 2'h0;
        end else begin
            unique case (svc_state)
                mic_pkg::MIC_IDLE: begin
                    if (arm_now) begin
                        svc_state <= mic_pkg::MIC_ARMED;
                        svc_cnt   <= 2'h0;
                    end
                end
                mic_pkg::MIC_ARMED: begin
                    if (!take_ok || take_now) begin
                        svc_state <= mic_pkg::MIC_IDLE; // R07
                    end else if (q1_now) begin
                        svc_cnt <= 2'(svc_cnt + 2'h1); // R08
                    end
                end
            endcase
        end
    end

    // core redirect strobes; only the return address is pushed, nothing else is saved
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            vector_load <= 1'b0;
            push_return <= 1'b0;
            vector_addr <= mic_pkg::VECTOR_ADDR;
            in_handler  <= 1'b0;
        end else begin
            vector_load <= take_now; // R04
            push_return <= take_now; // R04 R19
            vector_addr <= mic_pkg::VECTOR_ADDR;
            if (take_now)                       in_handler <= 1'b1;
            else if (return_from_handler_instr) in_handler <= 1'b0; // R05
        end
    end

    // bus slave: answer one cycle after the request appears
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus_ack      <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
            if (avs_read & ~bus_ack) avs_readdata <= rd_mux;
        end
    end

    // checks
    gie_reset_a: assert property (@(posedge clk) disable iff (!rst_b) // R03
        $rose(rst_b) |-> !global_irq_enable) else $error("global enable not clear after reset");
    gie_block_a: assert property (@(posedge clk) disable iff (!rst_b) // R02
        !global_irq_enable |=> !vector_load) else $error("vector taken with global enable clear");
    vector_entry_a: assert property (@(posedge clk) disable iff (!rst_b) // R04
        vector_load |-> !global_irq_enable && push_return && in_handler && vector_addr == 13'h0004)
        else $error("vector entry incomplete");
    return_gie_a: assert property (@(posedge clk) disable iff (!rst_b) // R05
        return_from_handler_instr && !take_now |=> global_irq_enable && !in_handler)
        else $error("return did not re-enable");
    tick_flag_a: assert property (@(posedge clk) disable iff (!rst_b) // R06
        tick_wrap |=> interrupt_control[mic_pkg::TICK_FLAG_BIT])
        else $error("tick wrap lost");
    latency_a: assert property (@(posedge clk) disable iff (!rst_b) // R08
        take_now |-> $past(arm_now, 12)) else $error("service latency wrong");
    ext_edge_a: assert property (@(posedge clk) disable iff (!rst_b) // R11
        edge_hit |-> ##[0:3] interrupt_control[mic_pkg::EXT_FLAG_BIT])
        else $error("pin edge not flagged");
    analog_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // R14
        1'b1 |=> (port_read_value & $past(analog_pin_select)) == 6'h00)
        else $error("analog pin read nonzero");
    wake_a: assert property (@(posedge clk) disable iff (!rst_b) // R21
        asleep && wake_pend |=> !asleep && wake_pulse) else $error("missed wake");
    periph_req_a: assert property (@(posedge clk) disable iff (!rst_b) // R20
        !interrupt_control[mic_pkg::PERIPH_EN_BIT] && !tick_pend && !ext_pend && !port_pend
        |-> !service_req) else $error("peripheral request ungated");

    vector_c: cover property (@(posedge clk) disable iff (!rst_b) vector_load);
    wake_c:   cover property (@(posedge clk) disable iff (!rst_b) wake_pulse && !global_irq_enable);
    return_c: cover property (@(posedge clk) disable iff (!rst_b)
        in_handler && return_from_handler_instr);
    abort_c:  cover property (@(posedge clk) disable iff (!rst_b)
        svc_state == mic_pkg::MIC_ARMED && !take_ok);

endmodule

/* hdl/mic_pkg.sv */
// constants for the interrupt controller: register map, field positions, reset values, timing
// assumes an avalon-mm host with 32-bit data and byte addressing; data sits in byte lane 0, except the config analog field in lane 1
// Notes on behaviour
// R01: eight sources; conversion, period match and capcomp exist only on the large variant.
// R02: global enable set passes individually enabled requests; clear blocks every request.
// R03: global enable is cleared by every reset.
// R04: servicing clears global enable, pushes return address, loads vector 0004h.
// R05: return-from-handler instruction leaves handler and sets global enable again.
// R06: flags set on their events regardless of any enable bit.
// R07: requests blocked by a global enable clear stay pending until re-enabled.
// R08: service starts 3 instruction cycles after sampling; async pin adds up to one.
// R09: handler software clears serviced flags before re-enabling, else request repeats.
// R10: pin, port-change and tick flags in control register; peripherals in own pair.
// R11: external pin edge is rising when edge select set, falling when clear.
// R12: each valid selected edge sets pin flag; its enable clear blocks its request.
// R13: pin event wakes from sleep only if its enable was set before sleeping.
// R14: analog pins read as zero and raise no interrupt.
// R15: tick counter wrap from FFh to 00h sets tick flag; its enable gates it.
// R16: change on any selected port pin sets port-change flag; its enable gates it.
// R17: a port change during a port operation may be missed.
// R18: pin flag may be set during Q4 or Q1 and requests are sampled at Q1.
// R19: only the return address is saved on handler entry.
// R20: peripheral request needs its flag, its enable and the group enable.
// R21: flagged enabled source wakes from sleep whatever global enable; no vector if clear.
// R22: service request raised when global enable set and any source flagged and enabled.
package mic_pkg;

    // register byte offsets, one aligned word each
    localparam logic [4:0] OFF_CONTROL    = 5'h00;
    localparam logic [4:0] OFF_CHANGE_SEL = 5'h04;
    localparam logic [4:0] OFF_PFLAGS     = 5'h08;
    localparam logic [4:0] OFF_PENABLES   = 5'h0C;
    localparam logic [4:0] OFF_CONFIG     = 5'h10;
    localparam logic [4:0] OFF_STATUS     = 5'h14;

    // interrupt_control fields
    localparam int GLOBAL_EN_BIT  = 7;
    localparam int PERIPH_EN_BIT  = 6;
    localparam int TICK_EN_BIT    = 5;
    localparam int EXT_EN_BIT     = 4;
    localparam int PORT_EN_BIT    = 3;
    localparam int TICK_FLAG_BIT  = 2;
    localparam int EXT_FLAG_BIT   = 1;
    localparam int PORT_FLAG_BIT  = 0;

    // peripheral flag and enable fields (same layout in both registers)
    localparam int CONV_BIT       = 6;
    localparam int CAPCOMP_BIT    = 5;
    localparam int COMPARATOR_BIT = 3;
    localparam int PERIOD_BIT     = 1;
    localparam int WIDE_TIMER_BIT = 0;
    localparam logic [7:0] PERIPH_MASK_LARGE = 8'h6B;
    localparam logic [7:0] PERIPH_MASK_SMALL = 8'h09;

    // config register fields
    localparam int EDGE_SEL_BIT   = 0;
    localparam int ANALOG_LSB     = 8;

    // status register fields
    localparam int STAT_REQ_BIT     = 0;
    localparam int STAT_HANDLER_BIT = 1;
    localparam int STAT_SLEEP_BIT   = 2;

    // port geometry
    localparam int PORT_W      = 6;
    localparam int EXT_PIN_IDX = 2;

    // reset values
    localparam logic [7:0]        CONTROL_RESET  = 8'h00;
    localparam logic [7:0]        PFLAGS_RESET   = 8'h00;
    localparam logic [7:0]        PENABLES_RESET = 8'h00;
    localparam logic [PORT_W-1:0] CHANGE_RESET   = 6'h00;
    localparam logic [PORT_W-1:0] ANALOG_RESET   = 6'h00;
    localparam logic              EDGE_RESET     = 1'b1;

    // timing
    localparam int          CLK_PERIOD_NS  = 40;
    localparam int          Q_PER_TCY      = 4;
    localparam int          LATENCY_TCY    = 3;
    localparam logic [1:0]  Q1_PHASE       = 2'h0;
    localparam logic [1:0]  Q4_PHASE       = 2'h3;
    localparam logic [1:0]  SVC_LAST       = 2'(LATENCY_TCY - 1);
    localparam logic [12:0] VECTOR_ADDR    = 13'h0004;
    localparam logic [7:0]  TICK_TOP       = 8'hFF;
    localparam logic [7:0]  TICK_ZERO      = 8'h00;

    typedef enum logic {MIC_IDLE, MIC_ARMED} mic_svc_e;

endpackage

/* bench/mic_core_model.sv */
// core sequencer stand-in: answers every vectoring with a return after a handler body
// assumes vector_load is a one-clock pulse on clk; software clears flags during the body
`timescale 1ns/1ns
module mic_core_model #(
    parameter int HANDLER_CYCLES = 30
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic vector_load,
    output logic      return_from_handler_instr
);
    int cnt;

    // the body length leaves the bench time to clear flags first, else the request repeats
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt <= 0;
            return_from_handler_instr <= 1'b0;
        end else begin
            return_from_handler_instr <= (cnt == 1);
            if (vector_load) begin
                cnt <= HANDLER_CYCLES;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

/* bench/mcu_interrupt_controller_tb_top.sv */
// self-checking bench: avalon master, event and pin stimulus, read-result monitor
// assumes the controller answers each bus request after one wait cycle
`timescale 1ns/1ns
module mcu_interrupt_controller_tb_top;
    localparam logic [4:0] CTL = mic_pkg::OFF_CONTROL;
    localparam logic [4:0] PFL = mic_pkg::OFF_PFLAGS;
    localparam logic [4:0] STA = mic_pkg::OFF_STATUS;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        ext_pin = 1'b0;
    logic [5:0]  port_pins = 6'h00;
    logic [7:0]  tick = 8'h00;
    logic [4:0]  ev = 5'h00;
    logic        pop = 1'b0;
    logic        slp = 1'b0;
    logic        q1, pr, wp;
    logic [5:0]  prv;
    logic [1:0]  ph = 2'h0;
    logic        ret, vector_load;
    logic [12:0] vector_addr;
    logic [7:0]  exp_q[$];
    int          n_errors = 0;
    int          samples_checked = 0;
    int          n_wake = 0;
    int          t, k;
    int          pbit[5] = '{mic_pkg::CONV_BIT, mic_pkg::CAPCOMP_BIT, mic_pkg::COMPARATOR_BIT,
                             mic_pkg::PERIOD_BIT, mic_pkg::WIDE_TIMER_BIT};

    mic_irq_ctrl dut (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .ext_irq_pin(ext_pin),
        .port_pins, .port_op_active(pop), .tick_counter(tick), .conversion_done_event(ev[0]),
        .capcomp_event(ev[1]), .comparator_event(ev[2]), .period_match_event(ev[3]),
        .wide_timer_overflow_event(ev[4]), .return_from_handler_instr(ret),
        .sleep_instr(slp), .q1_phase(q1), .service_req(), .vector_load, .push_return(pr),
        .vector_addr, .wake_pulse(wp), .asleep(), .port_read_value(prv));
    mic_core_model core (.clk, .rst_b, .vector_load, .return_from_handler_instr(ret));

    initial begin
        forever #20 clk = ~clk;
    end

    // one request held until waitrequest is sampled low, released only after that edge
    task automatic bus(input logic r, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_read <= r;
        avs_write <= !r;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b0, a, {24'h0, d});
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 32'h0);
    endtask
    task automatic final_report();
        $display("mismatches %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // oldest expectation against each read answer; vector address on every vectoring
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            samples_checked++;
            if (exp_q.size() == 0 || avs_readdata !== {24'h0, exp_q[0]}) begin
                n_errors++;
                $display("wrong value at %0t: read %h", $time, avs_readdata);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
        if (vector_load === 1'b1) begin
            samples_checked++;
            if (vector_addr !== mic_pkg::VECTOR_ADDR || pr !== 1'b1) begin
                n_errors++;
                $display("wrong value at %0t: vector %h", $time, vector_addr);
            end
        end
        if (wp === 1'b1) n_wake++;
        // q1 strobe counted from the first cycle after release
        if (rst_b !== 1'b1) ph <= 2'h0;
        else begin
            samples_checked++;
            if (q1 !== (ph == 2'h0)) begin
                n_errors++;
                $display("wrong value at %0t: phase strobe", $time);
            end
            ph <= 2'(ph + 2'h1);
        end
    end

    initial begin
        #(40 * 6000);
        n_errors++;
        $display("wrong value at %0t: timeout", $time);
        final_report();
    end

    initial begin
        void'($urandom(32'h3134f9e8));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd(CTL, 8'h00);
        rd(PFL, 8'h00);
        rd(5'h1C, 8'h00);
        // tick wrap with every enable clear still latches its flag
        @(posedge clk) tick <= 8'hFF;
        @(posedge clk) tick <= 8'h00;
        rd(CTL, 8'h04);
        wr(CTL, 8'h00);
        // both edge polarities; the pin is parked at the opposite level and the flag cleared before the selected edge
        for (int e = 0; e < 2; e++) begin
            bus(1'b0, mic_pkg::OFF_CONFIG, 32'(e));
            ext_pin <= ~e[0];
            repeat (10) @(posedge clk);
            wr(CTL, 8'h00);
            ext_pin <= e[0];
            repeat (10) @(posedge clk);
            rd(CTL, 8'h02);
            wr(CTL, 8'h00);
        end
        // one random selected pin flags; a change on an unselected pin does not
        k = $urandom_range(5, 0);
        wr(mic_pkg::OFF_CHANGE_SEL, 8'(1 << k));
        port_pins <= port_pins ^ 6'(1 << ((k + 1) % 6));
        repeat (10) @(posedge clk);
        rd(CTL, 8'h00);
        // a change while the core works the port is dropped
        pop <= 1'b1;
        port_pins <= port_pins ^ 6'(1 << k);
        repeat (10) @(posedge clk);
        pop <= 1'b0;
        rd(CTL, 8'h00);
        port_pins <= port_pins ^ 6'(1 << k);
        repeat (10) @(posedge clk);
        rd(CTL, 8'h01);
        wr(CTL, 8'h00);
        // an analog pin reads zero and raises no flag
        bus(1'b0, mic_pkg::OFF_CONFIG, 32'(1 << (k + mic_pkg::ANALOG_LSB)) | 32'h1);
        port_pins <= port_pins ^ 6'(1 << k);
        repeat (10) @(posedge clk);
        rd(CTL, 8'h00);
        samples_checked++;
        if (prv !== (port_pins & ~6'(1 << k))) begin
            n_errors++;
            $display("wrong value at %0t: port read %h", $time, prv);
        end
        bus(1'b0, mic_pkg::OFF_CONFIG, 32'h1);
        wr(CTL, 8'h00);
        // every peripheral source sets its own flag with all enables clear
        for (int i = 0; i < 5; i++) begin
            @(posedge clk) ev <= 5'(1 << i);
            @(posedge clk) ev <= 5'h00;
            rd(PFL, 8'(1 << pbit[i]));
            wr(PFL, 8'h00);
        end
        // comparator request gated by group and global enable, then serviced and returned
        wr(mic_pkg::OFF_PENABLES, 8'h08);
        // asleep with the group enable only; a comparator event wakes it
        wr(CTL, 8'h40);
        @(posedge clk) slp <= 1'b1;
        @(posedge clk) slp <= 1'b0;
        rd(STA, 8'h04);
        @(posedge clk) ev <= 5'h04;
        @(posedge clk) ev <= 5'h00;
        rd(STA, 8'h00);
        samples_checked++;
        if (n_wake != 1) begin
            n_errors++;
            $display("wrong value at %0t: wake count %0d", $time, n_wake);
        end
        @(posedge clk) ev <= 5'h04;
        @(posedge clk) ev <= 5'h00;
        wr(CTL, 8'h80);
        rd(STA, 8'h00);
        wr(CTL, 8'h40);
        rd(STA, 8'h00);
        wr(CTL, 8'hC0);
        rd(STA, 8'h01);
        t = 0;
        while (vector_load !== 1'b1 && t < 30) begin
            @(posedge clk);
            t++;
        end
        samples_checked++;
        if (t >= 30) begin
            n_errors++;
            $display("wrong value at %0t: no vectoring", $time);
        end
        rd(CTL, 8'h40);
        rd(STA, 8'h02);
        wr(PFL, 8'h00);
        repeat (40) @(posedge clk);
        rd(CTL, 8'hC0);
        rd(STA, 8'h00);
        final_report();
    end
endmodule
